// [pkg/guard_regs.svh]
`ifndef GUARD_REGS_SVH
`define GUARD_REGS_SVH
// apb byte offsets
`define OFS_WRITE_GUARD 12'h000
`define OFS_ROTATION 12'h004
`define OFS_VIEW_LEVEL 12'h008
`define OFS_GROUP_COUNT 12'h00c
`define OFS_GROUP_ADD 12'h010
`define OFS_GROUP_REMOVE 12'h014
`define OFS_STATUS 12'h018
`define OFS_REQ_NUM 12'h01c
`define OFS_REQ_CTRL 12'h020
`define OFS_RESULT 12'h024
// reset values
`define RST_WRITE_GUARD 16'h0000
`define RST_ROTATION 16'h0000
`define RST_VIEW_LEVEL 16'h0000
`define RST_GROUP_ADD 16'h270f
// codes
`define VAL_9999 16'h270f
`define GUARD_STOP_ONLY 16'h0000
`define GUARD_LOCK 16'h0001
`define GUARD_ANY 16'h0002
`define VIEW_EXTENDED 16'h0000
`define VIEW_USER 16'h0001
`define PNUM_MAX 16'h03e7
// parameter numbers
`define P_STALL_LVL 16'h0016
`define P_CARRIER 16'h0048
`define P_RESET_SEL 16'h004b
`define P_WRITE_GUARD 16'h004d
`define P_ROTATION 16'h004e
`define P_OPMODE 16'h004f
`define P_VIEW_LEVEL 16'h00a0
`define P_GROUP_COUNT 16'h00ac
`define P_GROUP_ADD 16'h00ad
`define P_GROUP_REMOVE 16'h00ae
`define P_SOFT_CARRIER 16'h00f0
`define P_CONTRAST 16'h03df
// request control bits
`define CTRL_GO_BIT 0
`define CTRL_WRITE_BIT 1
`define CTRL_CLEAR_BIT 2
`define CTRL_SIMPLE_BIT 3
`define CTRL_SRC_LSB 4
`endif

// [pkg/guard_pkg.sv]
package guard_pkg;
    typedef enum logic [1:0] {
        src_panel,
        src_unit,
        src_comm
    } source_e;
    typedef struct packed {
        logic running;
        logic panel_mode;
        logic fwd_key;
        logic rev_key;
        logic forward_start;
        logic reverse_start;
        logic comm_fwd;
        logic comm_rev;
    } drive_s;
    typedef struct packed {
        logic run_fwd;
        logic run_rev;
        logic allowed;
        logic refused;
        logic store_we;
        logic visible;
    } verdict_s;
endpackage : guard_pkg

// [design/group_store.sv]
`timescale 1ns/100ps
`default_nettype none
`include "guard_regs.svh"
module group_store #(
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // operations
    input wire logic add,
    input wire logic remove,
    input wire logic clear_all,
    input wire logic [15:0] pnum,
    input wire logic [15:0] look_num,
    // status
    output logic [4:0] count,
    output logic hit
);
    typedef struct packed {
        logic [DEPTH-1:0] used;
        logic [DEPTH-1:0][15:0] num;
        logic [4:0] count;
        logic hit;
    } state_s;
    state_s s_r;
    state_s s_nxt;
    logic found;
    logic placed;
    always_comb begin
        s_nxt = s_r;
        found = 1'b0;
        placed = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            if (s_r.used[i] && s_r.num[i] == pnum) begin
                found = 1'b1;
            end
        end
        if (clear_all) begin
            s_nxt.used = '0;
        end else if (remove) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (s_r.used[i] && s_r.num[i] == pnum) begin
                    s_nxt.used[i] = 1'b0;
                end
            end
        end else if (add && !found) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (!placed && !s_r.used[i]) begin
                    s_nxt.used[i] = 1'b1;
                    s_nxt.num[i] = pnum;
                    placed = 1'b1;
                end
            end
        end
        s_nxt.count = '0;
        s_nxt.hit = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            s_nxt.count = s_nxt.count + 5'(s_nxt.used[i]);
            if (s_nxt.used[i] && s_nxt.num[i] == look_num) begin
                s_nxt.hit = 1'b1;
            end
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign count = s_r.count;
    assign hit = s_r.hit;
endmodule : group_store
`default_nettype wire

// [design/start_limit.sv]
`timescale 1ns/100ps
`default_nettype none
`include "guard_regs.svh"
module start_limit (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // inputs
    input wire logic [15:0] rotation_limit_select,
    input wire guard_pkg::drive_s drive,
    // outputs
    output logic run_fwd,
    output logic run_rev
);
    typedef struct packed {
        logic fwd;
        logic rev;
    } state_s;
    state_s s_r;
    state_s s_nxt;
    logic want_fwd;
    logic want_rev;
    always_comb begin
        want_fwd = drive.fwd_key | drive.forward_start | drive.comm_fwd;
        want_rev = drive.rev_key | drive.reverse_start | drive.comm_rev;
        s_nxt.fwd = want_fwd && rotation_limit_select != 16'h0002; // [RULE9] [RULE10]
        s_nxt.rev = want_rev && rotation_limit_select != 16'h0001; // [RULE9] [RULE10]
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign run_fwd = s_r.fwd;
    assign run_rev = s_r.rev;
endmodule : start_limit
`default_nettype wire

// [design/parameter_access_guard.sv]
// Summary of operation
// [RULE1] guard 0: ordinary writes only when stopped and in panel mode
// [RULE2] guard 0: carrier settings writable running in panel mode, not external
// [RULE3] guard 1: writes refused, reads still served
// [RULE4] guard 1: parameter clear and all-clear refused
// [RULE5] guard 1: parameters 22, 75, 77, 79, 160 still writable
// [RULE6] guard 2: writes accepted in any mode and run state
// [RULE7] guard 2: listed motor/terminal/life/control parameters refused while running
// [RULE8] write-guard setting itself writable at any time
// [RULE9] rotation limit: 0 both, 1 no reverse, 2 no forward
// [RULE10] rotation limit gates keys, terminals and communication starts
// [RULE11] view level 9999 shows only the simple set on panel and unit
// [RULE12] view level 0 shows simple and extended sets
// [RULE13] view level 1 shows only user group entries
// [RULE14] group count reads 0 to 16; writing 9999 clears group
// [RULE15] group add registers parameter 0 to 999; reads 9999
// [RULE16] group remove deletes parameter 0 to 999 from group
// [RULE17] group parameters writable only with view level 0
// [RULE18] user group holds at most sixteen entries
// [RULE19] guard, view level and contrast always readable
// [RULE20] guard, view level and group parameters never registered
// [RULE21] refused write leaves value unchanged and reports refusal
`timescale 1ns/100ps
`default_nettype none
`include "guard_regs.svh"
module parameter_access_guard #(
    parameter int GROUP_DEPTH = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // drive state and start sources
    input wire guard_pkg::drive_s drive,
    // run command and store control
    output logic run_fwd,
    output logic run_rev,
    output guard_pkg::verdict_s verdict
);
    typedef struct packed {
        logic [15:0] guard;
        logic [15:0] rotation;
        logic [15:0] view;
        logic [15:0] req_num;
        logic [7:0] req_ctrl;
        logic busy;
        guard_pkg::verdict_s verdict;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic refused_sticky;
        logic [15:0] look;
    } state_s;
    state_s s_r;
    state_s s_nxt;
    logic [4:0] grp_count;
    logic grp_hit;
    logic grp_add;
    logic grp_remove;
    logic grp_clear;
    logic [15:0] grp_num;
    logic fwd_q;
    logic rev_q;
    logic access;
    logic [15:0] wv;
    logic ok;
    logic clear_cmd;
    logic simple;
    logic req_write;
    logic [15:0] rn;

    function automatic logic stop_only_list(input logic [15:0] n);
        return n == 16'd19 || n == 16'd23 || n == 16'd40 || n == 16'd48
            || n == 16'd60 || n == 16'd61 || n == 16'd66 || n == 16'd71
            || n == `P_OPMODE || (n >= 16'd80 && n <= 16'd84)
            || (n >= 16'd90 && n <= 16'd94) || n == 16'd96
            || (n >= 16'd178 && n <= 16'd184) || (n >= 16'd190 && n <= 16'd192)
            || (n >= 16'd255 && n <= 16'd258) || n == 16'd277
            || n == 16'd292 || n == 16'd293 || n == 16'd298 || n == 16'd329
            || n == 16'd343 || n == 16'd450 || n == 16'd541 || n == 16'd563
            || n == 16'd564 || n == 16'd800 || n == 16'd859;
    endfunction : stop_only_list

    function automatic logic group_param(input logic [15:0] n);
        return n == `P_GROUP_COUNT || n == `P_GROUP_ADD || n == `P_GROUP_REMOVE;
    endfunction : group_param

    // write decision for one parameter number
    function automatic logic write_ok(input logic [15:0] n, input logic [15:0] g,
                                      input logic [15:0] v, input guard_pkg::drive_s d);
        logic r;
        r = 1'b0;
        if (n == `P_WRITE_GUARD) begin
            r = 1'b1; // [RULE8]
        end else if (group_param(n) && v != `VIEW_EXTENDED) begin
            r = 1'b0; // [RULE17]
        end else if (g == `GUARD_LOCK) begin
            r = n == `P_STALL_LVL || n == `P_RESET_SEL || n == `P_OPMODE
                || n == `P_VIEW_LEVEL; // [RULE3] [RULE5]
        end else if (g == `GUARD_ANY) begin
            r = !(d.running && stop_only_list(n)); // [RULE6] [RULE7]
        end else if (n == `P_CARRIER || n == `P_SOFT_CARRIER) begin
            r = d.panel_mode; // [RULE2]
        end else begin
            r = d.panel_mode && !d.running; // [RULE1]
        end
        return r;
    endfunction : write_ok

    group_store #(
        .DEPTH(GROUP_DEPTH)
    ) u_group (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .add(grp_add),
        .remove(grp_remove),
        .clear_all(grp_clear),
        .pnum(grp_num),
        .look_num(s_r.look),
        .count(grp_count),
        .hit(grp_hit)
    );

    start_limit u_start (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .rotation_limit_select(s_r.rotation),
        .drive(drive),
        .run_fwd(fwd_q),
        .run_rev(rev_q)
    );

    always_comb begin
        s_nxt = s_r;
        access = psel && penable && !s_r.pready;
        wv = pwdata[15:0];
        grp_add = 1'b0;
        grp_remove = 1'b0;
        grp_clear = 1'b0;
        grp_num = wv;
        ok = 1'b0;
        rn = s_r.req_num;
        req_write = s_r.req_ctrl[`CTRL_WRITE_BIT];
        clear_cmd = s_r.req_ctrl[`CTRL_CLEAR_BIT];
        simple = s_r.req_ctrl[`CTRL_SIMPLE_BIT];
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        s_nxt.look = s_r.req_num;
        s_nxt.verdict.store_we = 1'b0;
        if (access) begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = '0;
            unique case (paddr)
                `OFS_WRITE_GUARD: begin
                    s_nxt.prdata = {16'h0000, s_r.guard};
                    if (pwrite) begin
                        s_nxt.guard = wv; // [RULE8]
                    end
                end
                `OFS_ROTATION: begin
                    s_nxt.prdata = {16'h0000, s_r.rotation};
                    if (pwrite && write_ok(`P_ROTATION, s_r.guard, s_r.view, drive)) begin
                        s_nxt.rotation = wv; // [RULE9]
                    end else if (pwrite) begin
                        s_nxt.pslverr = 1'b1; // [RULE21]
                    end
                end
                `OFS_VIEW_LEVEL: begin
                    s_nxt.prdata = {16'h0000, s_r.view};
                    if (pwrite && write_ok(`P_VIEW_LEVEL, s_r.guard, s_r.view, drive)) begin
                        s_nxt.view = wv;
                    end else if (pwrite) begin
                        s_nxt.pslverr = 1'b1; // [RULE21]
                    end
                end
                `OFS_GROUP_COUNT: begin
                    s_nxt.prdata = {27'h0000000, grp_count}; // [RULE14]
                    ok = write_ok(`P_GROUP_COUNT, s_r.guard, s_r.view, drive);
                    if (pwrite && ok) begin
                        grp_clear = wv == `VAL_9999; // [RULE14]
                    end else if (pwrite) begin
                        s_nxt.pslverr = 1'b1; // [RULE17]
                    end
                end
                `OFS_GROUP_ADD, `OFS_GROUP_REMOVE: begin
                    s_nxt.prdata = {16'h0000, `RST_GROUP_ADD}; // [RULE15]
                    ok = write_ok(`P_GROUP_ADD, s_r.guard, s_r.view, drive);
                    if (pwrite && ok && wv <= `PNUM_MAX) begin
                        if (paddr == `OFS_GROUP_REMOVE) begin
                            grp_remove = 1'b1; // [RULE16]
                        end else if (wv == `P_WRITE_GUARD || wv == `P_VIEW_LEVEL
                                     || group_param(wv)) begin
                            s_nxt.pslverr = 1'b1; // [RULE20]
                        end else if (grp_count < 5'(GROUP_DEPTH)) begin
                            grp_add = 1'b1; // [RULE15] [RULE18]
                        end else begin
                            s_nxt.pslverr = 1'b1; // [RULE18]
                        end
                    end else if (pwrite && (!ok || wv != `VAL_9999)) begin
                        s_nxt.pslverr = 1'b1; // [RULE21]
                    end
                end
                `OFS_STATUS: begin
                    s_nxt.prdata = {24'h000000, 1'b0, s_r.refused_sticky, s_r.verdict};
                    if (pwrite && wv[0]) begin
                        s_nxt.refused_sticky = 1'b0;
                    end
                end
                `OFS_REQ_NUM: begin
                    s_nxt.prdata = {16'h0000, s_r.req_num};
                    if (pwrite) begin
                        s_nxt.req_num = wv;
                    end
                end
                `OFS_REQ_CTRL: begin
                    s_nxt.prdata = {24'h000000, s_r.req_ctrl};
                    if (pwrite) begin
                        s_nxt.req_ctrl = pwdata[7:0];
                        s_nxt.busy = pwdata[`CTRL_GO_BIT];
                    end
                end
                `OFS_RESULT: begin
                    s_nxt.prdata = {24'h000000, 2'b00, s_r.verdict};
                end
                default: begin
                    s_nxt.pslverr = 1'b1;
                end
            endcase
        end
        // queued store request from panel, unit or communication
        if (s_r.busy) begin
            s_nxt.busy = 1'b0;
            if (clear_cmd) begin
                ok = s_r.guard != `GUARD_LOCK; // [RULE4]
            end else if (req_write) begin
                ok = write_ok(rn, s_r.guard, s_r.view, drive);
            end else begin
                ok = 1'b1; // [RULE3]
            end
            s_nxt.verdict.allowed = ok;
            s_nxt.verdict.refused = !ok; // [RULE21]
            s_nxt.verdict.store_we = ok && (req_write || clear_cmd); // [RULE21]
            if (!ok) begin
                s_nxt.refused_sticky = 1'b1;
            end
            if (s_r.req_ctrl[`CTRL_SRC_LSB +: 2] == 2'(guard_pkg::src_comm)
                || req_write || clear_cmd) begin
                s_nxt.verdict.visible = 1'b1;
            end else if (rn == `P_WRITE_GUARD || rn == `P_VIEW_LEVEL
                         || rn == `P_CONTRAST) begin
                s_nxt.verdict.visible = 1'b1; // [RULE19]
            end else if (s_r.view == `VAL_9999) begin
                s_nxt.verdict.visible = simple; // [RULE11]
            end else if (s_r.view == `VIEW_USER) begin
                s_nxt.verdict.visible = grp_hit; // [RULE13]
            end else begin
                s_nxt.verdict.visible = 1'b1; // [RULE12]
            end
        end
        s_nxt.verdict.run_fwd = fwd_q;
        s_nxt.verdict.run_rev = rev_q;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
            s_r.guard <= `RST_WRITE_GUARD;
            s_r.rotation <= `RST_ROTATION;
            s_r.view <= `RST_VIEW_LEVEL;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign verdict = s_r.verdict;
    assign run_fwd = s_r.verdict.run_fwd; // [RULE10]
    assign run_rev = s_r.verdict.run_rev; // [RULE10]

    rev_block_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_r.rotation == 16'h0001 && $stable(s_r.rotation) |-> ##2 !run_rev) // [RULE9]
        else $error("reverse start passed while blocked");
    fwd_block_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_r.rotation == 16'h0002 && $stable(s_r.rotation) |-> ##2 !run_fwd) // [RULE10]
        else $error("forward start passed while blocked");
    guard_free_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        psel && penable && pwrite && !pready && paddr == `OFS_WRITE_GUARD
        |=> s_r.guard == $past(pwdata[15:0]) && !pslverr) // [RULE8]
        else $error("write guard write lost");
    lock_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_r.busy && s_r.req_ctrl[`CTRL_CLEAR_BIT] && s_r.guard == `GUARD_LOCK
        |=> verdict.refused && !verdict.store_we) // [RULE4]
        else $error("clear accepted under lock");
    lock_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_r.busy && !s_r.req_ctrl[`CTRL_CLEAR_BIT] && s_r.req_ctrl[`CTRL_WRITE_BIT]
        && s_r.guard == `GUARD_LOCK && s_r.req_num == 16'd3 |=> verdict.refused) // [RULE3]
        else $error("write accepted under lock");
    stop_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_r.busy && !s_r.req_ctrl[`CTRL_CLEAR_BIT] && s_r.req_ctrl[`CTRL_WRITE_BIT]
        && s_r.guard == `GUARD_STOP_ONLY && drive.running && s_r.req_num == 16'd3
        |=> verdict.refused) // [RULE1]
        else $error("running write accepted");
    run_list_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_r.busy && !s_r.req_ctrl[`CTRL_CLEAR_BIT] && s_r.req_ctrl[`CTRL_WRITE_BIT]
        && s_r.guard == `GUARD_ANY && drive.running && s_r.req_num == 16'd800
        |=> verdict.refused) // [RULE7]
        else $error("listed parameter written while running");
    count_max_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        grp_count <= 5'd16) // [RULE18]
        else $error("group count above sixteen");
    refuse_we_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        verdict.refused |-> !verdict.store_we) // [RULE21]
        else $error("refused write stored");
    write_cv: cover property (@(posedge clk_sys) disable iff (!rstn)
        verdict.store_we);
    refuse_cv: cover property (@(posedge clk_sys) disable iff (!rstn)
        verdict.refused);
    group_cv: cover property (@(posedge clk_sys) disable iff (!rstn)
        grp_count == 5'd16);
endmodule : parameter_access_guard
`default_nettype wire

// [testbench/apb_panel.sv]
`timescale 1ns/100ps
`default_nettype none
module apb_panel (
    // clock
    input wire logic clk_sys,
    // apb request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    // apb answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    // one transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask : xfer
endmodule : apb_panel
`default_nettype wire

// [testbench/test_parameter_access_guard.sv]
`timescale 1ns/100ps
`default_nettype none
`include "guard_regs.svh"
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
    $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
module test_parameter_access_guard;
    typedef struct packed {
        logic [15:0] guard;
        logic run;
        logic panel;
        logic [15:0] pnum;
        logic ok;
    } row_s;
    logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr, run_fwd, run_rev, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    guard_pkg::drive_s drive;
    guard_pkg::verdict_s verdict;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    row_s rows [14] = '{
        '{16'h0000, 1'b0, 1'b1, 16'h0003, 1'b1}, '{16'h0000, 1'b1, 1'b1, 16'h0003, 1'b0},
        '{16'h0000, 1'b0, 1'b0, 16'h0003, 1'b0}, '{16'h0000, 1'b1, 1'b1, `P_CARRIER, 1'b1},
        '{16'h0000, 1'b1, 1'b0, `P_SOFT_CARRIER, 1'b0}, '{16'h0001, 1'b0, 1'b1, 16'h0003, 1'b0},
        '{16'h0001, 1'b0, 1'b1, `P_STALL_LVL, 1'b1}, '{16'h0001, 1'b0, 1'b1, `P_RESET_SEL, 1'b1},
        '{16'h0001, 1'b0, 1'b1, `P_OPMODE, 1'b1}, '{16'h0001, 1'b0, 1'b1, `P_VIEW_LEVEL, 1'b1},
        '{16'h0002, 1'b1, 1'b0, 16'h0003, 1'b1}, '{16'h0002, 1'b1, 1'b1, 16'h0013, 1'b0},
        '{16'h0002, 1'b1, 1'b0, 16'h0320, 1'b0}, '{16'h0002, 1'b1, 1'b1, `P_OPMODE, 1'b0}};
    parameter_access_guard dut_u (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .drive(drive), .run_fwd(run_fwd),
        .run_rev(run_rev), .verdict(verdict));
    apb_panel panel_u (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic wr(input logic [11:0] a, input logic [15:0] v, input logic err);
        panel_u.xfer(1'b1, a, {16'h0000, v}, q, e);
        `CHK("pslverr", err, e)
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [15:0] v, input logic err);
        panel_u.xfer(1'b0, a, 32'h0000_0000, q, e);
        `CHK("prdata", {16'h0000, v}, q)
        `CHK("pslverr", err, e)
    endtask : rd
    task automatic req(input logic [15:0] pnum, input logic [7:0] ctrl);
        panel_u.xfer(1'b1, `OFS_REQ_NUM, {16'h0000, pnum}, q, e);
        panel_u.xfer(1'b1, `OFS_REQ_CTRL, {24'h000000, ctrl}, q, e);
        repeat (3) @(posedge clk_sys);
    endtask : req
    task automatic set_drv(input logic [7:0] b);
        @(posedge clk_sys);
        drive <= guard_pkg::drive_s'(b);
    endtask : set_drv
    task automatic pulse_dir(input logic [7:0] b, input logic f, input logic r);
        set_drv(8'h40 | b);
        repeat (3) @(posedge clk_sys);
        `CHK("run_fwd", f, run_fwd)
        `CHK("run_rev", r, run_rev)
        set_drv(8'h40);
        repeat (3) @(posedge clk_sys);
    endtask : pulse_dir
    initial begin
        rstn = 1'b0;
        drive = guard_pkg::drive_s'(8'h40);
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(`OFS_WRITE_GUARD, `RST_WRITE_GUARD, 1'b0);
        rd(`OFS_ROTATION, `RST_ROTATION, 1'b0);
        rd(`OFS_VIEW_LEVEL, `RST_VIEW_LEVEL, 1'b0);
        rd(`OFS_GROUP_ADD, `RST_GROUP_ADD, 1'b0);
        rd(`OFS_GROUP_COUNT, 16'h0000, 1'b0);
        rd(12'hffc, 16'h0000, 1'b1);
        $display("test reset values done");
        foreach (rows[i]) begin
            set_drv({rows[i].run, rows[i].panel, 6'h00});
            wr(`OFS_WRITE_GUARD, rows[i].guard, 1'b0);
            req(rows[i].pnum, 8'h03);
            `CHK("allowed", rows[i].ok, verdict.allowed)
            `CHK("refused", ~rows[i].ok, verdict.refused)
        end
        $display("test write table done");
        set_drv(8'h40);
        wr(`OFS_WRITE_GUARD, `GUARD_LOCK, 1'b0);
        rd(`OFS_WRITE_GUARD, `GUARD_LOCK, 1'b0);
        req(16'h0003, 8'h05);
        `CHK("clear refused", 1'b1, verdict.refused)
        rd(`OFS_STATUS, 16'h0045, 1'b0);
        wr(`OFS_STATUS, 16'h0001, 1'b0);
        rd(`OFS_STATUS, 16'h0005, 1'b0);
        rd(`OFS_RESULT, 16'h0005, 1'b0);
        wr(`OFS_ROTATION, 16'h0002, 1'b1);
        rd(`OFS_ROTATION, `RST_ROTATION, 1'b0);
        wr(`OFS_WRITE_GUARD, `GUARD_STOP_ONLY, 1'b0);
        $display("test lock done");
        for (int lim = 0; lim < 3; lim++) begin
            wr(`OFS_ROTATION, 16'(lim), 1'b0);
            for (int k = 0; k < 3; k++) begin
                pulse_dir(8'h20 >> (2 * k), lim != 2, 1'b0);
                pulse_dir(8'h10 >> (2 * k), 1'b0, lim != 1);
            end
        end
        $display("test rotation limit done");
        for (int j = 1; j <= 16; j++) wr(`OFS_GROUP_ADD, 16'(j), 1'b0);
        wr(`OFS_GROUP_ADD, 16'h0011, 1'b1);
        rd(`OFS_GROUP_COUNT, 16'h0010, 1'b0);
        wr(`OFS_GROUP_REMOVE, 16'h0003, 1'b0);
        wr(`OFS_GROUP_ADD, `P_WRITE_GUARD, 1'b1);
        rd(`OFS_GROUP_COUNT, 16'h000f, 1'b0);
        wr(`OFS_GROUP_COUNT, `VAL_9999, 1'b0);
        rd(`OFS_GROUP_COUNT, 16'h0000, 1'b0);
        wr(`OFS_GROUP_ADD, 16'h0005, 1'b0);
        wr(`OFS_VIEW_LEVEL, `VIEW_USER, 1'b0);
        wr(`OFS_GROUP_ADD, 16'h0006, 1'b1);
        req(16'h0005, 8'h01);
        `CHK("visible", 1'b1, verdict.visible)
        req(16'h0006, 8'h01);
        `CHK("visible", 1'b0, verdict.visible)
        req(`P_CONTRAST, 8'h01);
        `CHK("visible", 1'b1, verdict.visible)
        wr(`OFS_VIEW_LEVEL, `VAL_9999, 1'b0);
        req(16'h0006, 8'h09);
        `CHK("visible", 1'b1, verdict.visible)
        req(16'h0006, 8'h01);
        `CHK("visible", 1'b0, verdict.visible)
        $display("test user group done");
        give_verdict();
    end
endmodule : test_parameter_access_guard
`default_nettype wire
